//--- logic/lpsc_pkg.sv
package lpsc_pkg;

    // serial word layout
    localparam int LPSC_WORD_W = 24;
    localparam int LPSC_NUM_REGS = 8;
    localparam int LPSC_IDX_W = 3;
    localparam int LPSC_IDX_LSB = 0;
    localparam logic [2:0] LPSC_FIRST_IDX = 3'h7;
    localparam logic [2:0] LPSC_LAST_IDX = 3'h0;

    // link side bit counter, wraps freely; only differences are used
    localparam int LPSC_CNT_W = 8;
    localparam logic [7:0] LPSC_BITS_PER_WORD = 8'h18;
    localparam int LPSC_SYNC_STAGES = 2;

    // register 5: lo path and modulator control
    localparam int LPSC_CFG_LO_PATH = 5;
    localparam int LPSC_LO_EN_BIT = 10;
    localparam int LPSC_LO_DBL_BIT = 11;
    localparam int LPSC_RF_EN_BIT = 12;

    // register 6: vco control and enable
    localparam int LPSC_CFG_VCO = 6;
    localparam int LPSC_PLL_MSB = 20;
    localparam int LPSC_PLL_LSB = 17;

    // reset contents, register 0 in the low word
    localparam logic [7:0][23:0] LPSC_CFG_RESET = {
        24'h000000, 24'h000000, 24'h000000, 24'h000000,
        24'h000000, 24'h000000, 24'h000000, 24'h0001C0
    };

    // bus map, byte addresses
    localparam logic [7:0] LPSC_OFF_CFG0 = 8'h00;
    localparam logic [7:0] LPSC_OFF_STATUS = 8'h20;
    localparam logic [7:0] LPSC_OFF_CTRL = 8'h24;
    localparam int LPSC_CTRL_RESTART_BIT = 0;

    // status fields
    localparam int LPSC_ST_INIT_DONE = 0;
    localparam int LPSC_ST_ORDER_ERR = 1;
    localparam int LPSC_ST_LO_OUT = 2;
    localparam int LPSC_ST_LO_DBL = 3;
    localparam int LPSC_ST_PLL_OFF = 4;
    localparam int LPSC_ST_COUPLE = 5;
    localparam int LPSC_ST_LO_SEL = 6;
    localparam int LPSC_ST_EXPECT_LSB = 8;

    localparam logic [1:0] LPSC_HTRANS_NONSEQ = 2'h2;
    localparam logic LPSC_HRESP_OKAY = 1'h0;

    typedef struct packed {
        logic lo_out_en;
        logic lo_out_dbl;
        logic ext_lo_in;
        logic pll_off;
        logic rf_out_en;
        logic couple_fault;
    } lpsc_lo_ctl_type;

endpackage

//--- logic/lpsc_top.sv
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps

// Function
// - internal lo out needs select pin and settings
// - lo port accepts external lo input
// - pll off when reg6 bits 20:17 zero
// - configuration loaded only via serial port
// - eight registers of 24 bits each
// - after first pass any order accepted
// - low three word bits pick register
// - register 6 holds vco control and enable
module lpsc_top
    import lpsc_pkg::*;
#(
    parameter int NUM_REGS = LPSC_NUM_REGS,
    parameter int WORD_W = LPSC_WORD_W
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_ser_clk,
    input wire logic i_ser_data,
    input wire logic i_ser_load,
    input wire logic i_lo_output_select,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic [31:0] o_hrdata,
    output logic o_hresp,
    output logic o_lo_out_en,
    output logic o_lo_out_dbl,
    output logic o_ext_lo_in,
    output logic o_pll_off,
    output logic o_rf_out_en,
    output logic o_couple_fault,
    output logic o_init_done,
    output logic o_order_error,
    output logic o_commit
);

    typedef struct packed {
        logic [1:0] rst_sync;
        logic [WORD_W-1:0] shift;
        logic [LPSC_CNT_W-1:0] count;
    } lpsc_link_state_type;

    typedef struct packed {
        logic load_s1;
        logic load_s2;
        logic load_prev;
        logic lo_sel_s1;
        logic lo_sel_s2;
        logic [LPSC_CNT_W-1:0] last_count;
        logic [NUM_REGS-1:0][WORD_W-1:0] cfg;
        logic [LPSC_IDX_W-1:0] expect_idx;
        logic init_done;
        logic order_error;
        logic commit;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic hreadyout;
        logic [31:0] hrdata;
        logic hresp;
        lpsc_lo_ctl_type lo;
    } lpsc_main_state_type;

    lpsc_link_state_type link_reg;
    lpsc_link_state_type link_next;
    lpsc_main_state_type state_reg;
    lpsc_main_state_type state_next;

    logic link_rst;
    logic load_rise;
    logic [LPSC_CNT_W-1:0] bit_diff;
    logic word_full;
    logic [LPSC_IDX_W-1:0] word_idx;
    logic addr_ok;
    logic [7:0] addr_off;

    // link domain: the host clock shifts msb first; the reset is brought over
    // so the counter starts known, which needs a few serial edges during reset
    assign link_rst = link_reg.rst_sync[1];

    always_comb begin
        link_next = link_reg;
        link_next.rst_sync = {link_reg.rst_sync[0], i_sys_rst};
        if (link_rst) begin
            link_next.shift = '0;
            link_next.count = '0;
        end else begin
            link_next.shift = {link_reg.shift[WORD_W-2:0], i_ser_data};
            link_next.count = link_reg.count + 8'h01;
        end
    end

    always_ff @(posedge i_ser_clk) begin
        link_reg <= link_next;
    end

    // shift and count stand still while the load line is high, so sampling
    // them on the system edge after the synchronised rise is safe; a host that
    // toggles the serial clock with load high corrupts the frame
    assign load_rise = state_reg.load_s2 & ~state_reg.load_prev;
    assign bit_diff = link_reg.count - state_reg.last_count;
    assign word_full = (bit_diff == LPSC_BITS_PER_WORD);
    assign word_idx = link_reg.shift[LPSC_IDX_LSB +: LPSC_IDX_W];
    assign addr_ok = i_hsel & i_hready & (i_htrans == LPSC_HTRANS_NONSEQ);
    assign addr_off = i_haddr[7:0];

    always_comb begin
        state_next = state_reg;
        state_next.load_s1 = i_ser_load;
        state_next.load_s2 = state_reg.load_s1;
        state_next.load_prev = state_reg.load_s2;
        state_next.lo_sel_s1 = i_lo_output_select;
        state_next.lo_sel_s2 = state_reg.lo_sel_s1;
        state_next.commit = 1'b0;

        // software restart of first-pass tracking; a commit below still wins
        if (state_reg.wr_pend && state_reg.wr_addr == LPSC_OFF_CTRL && i_hwdata[LPSC_CTRL_RESTART_BIT]) begin
            state_next.expect_idx = LPSC_FIRST_IDX;
            state_next.init_done = 1'b0;
            state_next.order_error = 1'b0;
        end

        if (load_rise) begin
            state_next.last_count = link_reg.count;
            if (word_full) begin
                state_next.cfg[word_idx] = link_reg.shift;
                state_next.commit = 1'b1;
                if (!state_next.init_done) begin
                    if (word_idx == state_next.expect_idx) begin
                        if (word_idx == LPSC_LAST_IDX) begin
                            state_next.init_done = 1'b1;
                        end else begin
                            state_next.expect_idx = word_idx - 3'h1;
                        end
                    end else begin
                        state_next.order_error = 1'b1;
                        state_next.expect_idx = (word_idx == LPSC_FIRST_IDX) ? 3'h6 : LPSC_FIRST_IDX;
                    end
                end
                // once the pass is done every register is free to update
            end
        end

        // bus: zero wait states; cfg words are read only from here
        state_next.hreadyout = 1'b1;
        // registered so that every port leaves a flip-flop
        state_next.hresp = LPSC_HRESP_OKAY;
        state_next.wr_pend = addr_ok & i_hwrite;
        state_next.wr_addr = addr_off;
        if (addr_ok && !i_hwrite) begin
            state_next.hrdata = 32'h00000000;
            if (i_haddr[31:8] == 24'h000000 && addr_off[1:0] == 2'h0) begin
                if (addr_off < LPSC_OFF_STATUS) begin
                    state_next.hrdata[WORD_W-1:0] = state_reg.cfg[addr_off[4:2]];
                end else if (addr_off == LPSC_OFF_STATUS) begin
                    state_next.hrdata[LPSC_ST_INIT_DONE] = state_reg.init_done;
                    state_next.hrdata[LPSC_ST_ORDER_ERR] = state_reg.order_error;
                    state_next.hrdata[LPSC_ST_LO_OUT] = state_reg.lo.lo_out_en;
                    state_next.hrdata[LPSC_ST_LO_DBL] = state_reg.lo.lo_out_dbl;
                    state_next.hrdata[LPSC_ST_PLL_OFF] = state_reg.lo.pll_off;
                    state_next.hrdata[LPSC_ST_COUPLE] = state_reg.lo.couple_fault;
                    state_next.hrdata[LPSC_ST_LO_SEL] = state_reg.lo_sel_s2;
                    state_next.hrdata[LPSC_ST_EXPECT_LSB +: LPSC_IDX_W] = state_reg.expect_idx;
                end
            end
        end

        // lo path, from the committed registers
        state_next.lo.rf_out_en = state_reg.cfg[LPSC_CFG_LO_PATH][LPSC_RF_EN_BIT];
        // the lo output is also gated by rf enable, so a host that leaves the
        // lo on with rf off never drives the port; the fault flag reports it
        state_next.lo.lo_out_en = state_reg.lo_sel_s2
            & state_reg.cfg[LPSC_CFG_LO_PATH][LPSC_LO_EN_BIT]
            & state_reg.cfg[LPSC_CFG_LO_PATH][LPSC_RF_EN_BIT];
        state_next.lo.lo_out_dbl = state_reg.lo_sel_s2 & state_reg.cfg[LPSC_CFG_LO_PATH][LPSC_LO_DBL_BIT];
        state_next.lo.couple_fault = state_reg.cfg[LPSC_CFG_LO_PATH][LPSC_LO_EN_BIT]
            & ~state_reg.cfg[LPSC_CFG_LO_PATH][LPSC_RF_EN_BIT];
        state_next.lo.ext_lo_in = ~state_reg.lo_sel_s2;
        state_next.lo.pll_off = (state_reg.cfg[LPSC_CFG_VCO][LPSC_PLL_MSB:LPSC_PLL_LSB] == 4'h0);

        if (i_sys_rst) begin
            state_next = '0;
            state_next.cfg = LPSC_CFG_RESET;
            state_next.expect_idx = LPSC_FIRST_IDX;
            state_next.hreadyout = 1'b1;
            state_next.lo.ext_lo_in = 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        state_reg <= state_next;
    end

    assign o_hreadyout = state_reg.hreadyout;
    assign o_hrdata = state_reg.hrdata;
    assign o_hresp = state_reg.hresp;
    assign o_lo_out_en = state_reg.lo.lo_out_en;
    assign o_lo_out_dbl = state_reg.lo.lo_out_dbl;
    assign o_ext_lo_in = state_reg.lo.ext_lo_in;
    assign o_pll_off = state_reg.lo.pll_off;
    assign o_rf_out_en = state_reg.lo.rf_out_en;
    assign o_couple_fault = state_reg.lo.couple_fault;
    assign o_init_done = state_reg.init_done;
    assign o_order_error = state_reg.order_error;
    assign o_commit = state_reg.commit;

    chk_commit_full: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        $rose(state_reg.commit) |-> $past(load_rise) && $past(bit_diff) == LPSC_BITS_PER_WORD
    ) else $error("commit without a full word");

    chk_partial_drop: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        load_rise && !word_full |=> $stable(state_reg.cfg) && !state_reg.commit
    ) else $error("partial word changed a register");

    chk_index_decode: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        load_rise && word_full |=> state_reg.cfg[$past(word_idx)] == $past(link_reg.shift)
    ) else $error("word not stored at its index");

    chk_bus_no_write: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        state_reg.wr_pend && !load_rise |=> $stable(state_reg.cfg)
    ) else $error("bus write altered configuration");

    chk_lo_gate: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        state_reg.lo.lo_out_en |-> $past(state_reg.lo_sel_s2)
            && $past(state_reg.cfg[LPSC_CFG_LO_PATH][LPSC_LO_EN_BIT])
    ) else $error("lo output without select and setting");

    chk_lo_rf_tie: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        !state_reg.lo.rf_out_en |-> !state_reg.lo.lo_out_en
    ) else $error("lo output on with rf output off");

    chk_ext_lo: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        !state_reg.lo_sel_s2 |=> state_reg.lo.ext_lo_in && !state_reg.lo.lo_out_en
    ) else $error("external lo not accepted");

    chk_pll_off: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        $changed(state_reg.cfg[LPSC_CFG_VCO]) |=>
            state_reg.lo.pll_off == ($past(state_reg.cfg[LPSC_CFG_VCO][LPSC_PLL_MSB:LPSC_PLL_LSB]) == 4'h0)
    ) else $error("pll off does not follow register 6");

    chk_pass_end: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        $rose(state_reg.init_done) |-> $past(state_reg.expect_idx) == LPSC_LAST_IDX
            && $past(word_idx) == LPSC_LAST_IDX && $past(load_rise)
    ) else $error("first pass ended out of order");

    chk_any_order: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        state_reg.init_done && load_rise && word_full && !state_reg.wr_pend |=>
            state_reg.init_done && !$rose(state_reg.order_error)
    ) else $error("update after first pass flagged");

    // gated by the sampled reset: the last reset edge after release must not start a check
    chk_link_shift: assert property (
        @(posedge i_ser_clk) disable iff (link_rst)
        !link_rst |=> link_reg.shift[0] == $past(i_ser_data)
            && link_reg.count == $past(link_reg.count) + 8'h01
    ) else $error("serial shift lost a bit");

    chk_commit_pulse: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        state_reg.commit |=> !state_reg.commit
    ) else $error("commit held longer than one cycle");

    chk_dbl_gate: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        state_reg.lo.lo_out_dbl |-> $past(state_reg.lo_sel_s2)
            && $past(state_reg.cfg[LPSC_CFG_LO_PATH][LPSC_LO_DBL_BIT])
    ) else $error("double lo output without select and setting");

    chk_rf_follow: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        !i_sys_rst |=> state_reg.lo.rf_out_en == $past(state_reg.cfg[LPSC_CFG_LO_PATH][LPSC_RF_EN_BIT])
    ) else $error("rf output does not follow register 5");

    chk_couple_flag: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        !i_sys_rst |=> state_reg.lo.couple_fault == ($past(state_reg.cfg[LPSC_CFG_LO_PATH][LPSC_LO_EN_BIT])
            && !$past(state_reg.cfg[LPSC_CFG_LO_PATH][LPSC_RF_EN_BIT]))
    ) else $error("coupling fault flag wrong");

    // a restart in the same cycle moves the expected index first, so it is left out
    chk_order_flag: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        load_rise && word_full && !state_reg.init_done && !state_reg.wr_pend
            && word_idx != state_reg.expect_idx |=> state_reg.order_error
    ) else $error("out of order word not flagged");

    chk_pass_step: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        load_rise && word_full && !state_reg.init_done && !state_reg.wr_pend
            && word_idx == state_reg.expect_idx && word_idx != LPSC_LAST_IDX |=>
            state_reg.expect_idx == $past(word_idx) - 3'h1 && !state_reg.init_done
    ) else $error("first pass did not step down");

    chk_restart_clear: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        state_reg.wr_pend && state_reg.wr_addr == LPSC_OFF_CTRL
            && i_hwdata[LPSC_CTRL_RESTART_BIT] && !load_rise |=>
            state_reg.expect_idx == LPSC_FIRST_IDX && !state_reg.init_done && !state_reg.order_error
    ) else $error("restart did not clear first pass tracking");

    // the bus answer is fixed: no wait states and never an error response
    chk_bus_ready: assert property (
        @(posedge i_mclk) disable iff (i_sys_rst)
        !i_sys_rst |=> state_reg.hreadyout && state_reg.hresp == LPSC_HRESP_OKAY
    ) else $error("bus answer not ready or not okay");

    cov_first_pass: cover property (
        @(posedge i_mclk) disable iff (i_sys_rst) $rose(state_reg.init_done)
    );

    cov_partial: cover property (
        @(posedge i_mclk) disable iff (i_sys_rst) load_rise && !word_full
    );

    cov_lo_double: cover property (
        @(posedge i_mclk) disable iff (i_sys_rst) state_reg.lo.lo_out_en && state_reg.lo.lo_out_dbl
    );

    cov_order_err: cover property (
        @(posedge i_mclk) disable iff (i_sys_rst) $rose(state_reg.order_error)
    );

    cov_restart: cover property (
        @(posedge i_mclk) disable iff (i_sys_rst) $fell(state_reg.init_done)
    );

endmodule

//--- tb/lpsc_ser_host.sv
`timescale 1ns/1ps
module lpsc_ser_host (
    output logic o_ser_clk,
    output logic o_ser_data,
    output logic o_ser_load
);
    initial begin
        o_ser_clk = 1'b0;
        o_ser_data = 1'b0;
        o_ser_load = 1'b0;
    end
    // clock stands still between frames; used alone to start the link counter in reset and to drain the link reset after release
    task automatic pulses(input int n);
        repeat (n) begin
            #6 o_ser_clk = 1'b1;
            #6 o_ser_clk = 1'b0;
        end
    endtask
    // msb first, data moves on the falling edge; fewer than 24 bits makes a frame to be dropped
    task automatic send(input logic [23:0] word, input int nbits);
        for (int i = nbits - 1; i >= 0; i--) begin
            o_ser_data = word[i];
            pulses(1);
        end
        // released line must not keep showing the last bit
        o_ser_data = ~o_ser_data;
        #20 o_ser_load = 1'b1;
        #150 o_ser_load = 1'b0;
        #20;
    endtask
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
    import lpsc_pkg::*;
    logic i_mclk, i_sys_rst, i_lo_output_select, i_hsel, i_hwrite;
    logic [1:0] i_htrans;
    logic [31:0] i_haddr, i_hwdata, o_hrdata;
    logic o_hreadyout, o_hresp, o_init_done, o_order_error, o_commit;
    logic ser_clk, ser_data, ser_load;
    logic [5:0] lo_seen;
    logic [7:0][23:0] exp_cfg = LPSC_CFG_RESET;
    int fail_count = 0;
    int samples_checked = 0;
    int commits = 0;
    int seed = 32'haa5a;

    lpsc_ser_host host (.o_ser_clk(ser_clk), .o_ser_data(ser_data), .o_ser_load(ser_load));
    lpsc_top dut (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ser_clk(ser_clk), .i_ser_data(ser_data),
        .i_ser_load(ser_load), .i_lo_output_select(i_lo_output_select), .i_hsel(i_hsel),
        .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2),
        .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hreadyout(o_hreadyout),
        .o_hrdata(o_hrdata), .o_hresp(o_hresp), .o_lo_out_en(lo_seen[5]), .o_lo_out_dbl(lo_seen[4]),
        .o_ext_lo_in(lo_seen[3]), .o_pll_off(lo_seen[2]), .o_rf_out_en(lo_seen[1]),
        .o_couple_fault(lo_seen[0]), .o_init_done(o_init_done), .o_order_error(o_order_error),
        .o_commit(o_commit)
    );

    initial begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end

    always @(posedge i_mclk) begin
        if (o_commit === 1'b1) commits <= commits + 1;
    end

    task automatic give_verdict();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (o_hreadyout !== 1'b1 && n < 40);
        if (n >= 40) begin
            fail_count++;
            give_verdict();
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        i_hsel <= 1'b1;
        i_haddr <= a;
        i_htrans <= LPSC_HTRANS_NONSEQ;
        i_hwrite <= wr;
        wait_rdy();
        i_htrans <= 2'h0;
        i_hwdata <= d;
        wait_rdy();
        r = o_hrdata;
    endtask

    task automatic check_reg(input int idx);
        logic [31:0] r;
        bus(1'b0, 32'(4 * idx), 32'h0, r);
        check("cfg", r, {8'h00, exp_cfg[idx]});
        check("hresp", 32'(o_hresp), 32'(LPSC_HRESP_OKAY));
    endtask

    // a word commits only when exactly 24 bits preceded the load strobe
    task automatic frame(input logic [23:0] w, input int nb);
        int c;
        c = commits;
        host.send(w, nb);
        repeat (3) @(posedge i_mclk);
        if (nb == 24) exp_cfg[w[2:0]] = w;
        check("commit", 32'(commits - c), 32'(nb == 24));
        check_reg(w[2:0]);
    endtask

    function automatic logic [5:0] lo_exp(input logic sel, input logic [23:0] r5, input logic [23:0] r6);
        logic en, rf;
        en = r5[LPSC_LO_EN_BIT];
        rf = r5[LPSC_RF_EN_BIT];
        lo_exp = {sel & en & rf, sel & r5[LPSC_LO_DBL_BIT], ~sel,
            r6[LPSC_PLL_MSB:LPSC_PLL_LSB] == 4'h0, rf, en & ~rf};
    endfunction

    initial begin
        logic [31:0] r;
        logic [23:0] w;
        i_sys_rst = 1'b1;
        i_lo_output_select = 1'b0;
        i_hsel = 1'b0;
        i_hwrite = 1'b0;
        i_htrans = 2'h0;
        i_haddr = 32'h0;
        i_hwdata = 32'h0;
        fork
            host.pulses(4);
        join_none
        repeat (6) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        // two serial edges drain the link reset so the first frame keeps all 24 bits
        host.pulses(2);
        @(posedge i_mclk);
        for (int i = 0; i < 8; i++) check_reg(i);
        bus(1'b0, 32'h40, 32'h0, r);
        check("unmapped", r, 32'h0);
        bus(1'b0, {24'h0, LPSC_OFF_STATUS}, 32'h0, r);
        check("status", r, 32'h710);
        for (int i = 7; i >= 0; i--) begin
            w = $random(seed);
            w[2:0] = 3'(i);
            frame(w, 24);
            check("init", 32'({o_init_done, o_order_error}), 32'(i == 0) << 1);
        end
        w = $random(seed);
        w[2:0] = 3'h2;
        frame(w, 23);
        repeat (6) begin
            w = $random(seed);
            frame(w, 24);
            check("any_order", 32'({o_init_done, o_order_error}), 32'h2);
        end
        for (int k = 0; k < 16; k++) begin
            i_lo_output_select <= k[3];
            w = $random(seed);
            w[2:0] = 3'h6;
            if (k[0]) w[LPSC_PLL_MSB:LPSC_PLL_LSB] = 4'h0;
            frame(w, 24);
            w = exp_cfg[5];
            w[LPSC_RF_EN_BIT:LPSC_LO_EN_BIT] = k[2:0];
            frame(w, 24);
            check("lo", 32'(lo_seen), 32'(lo_exp(k[3], exp_cfg[5], exp_cfg[6])));
        end
        bus(1'b1, {24'h0, LPSC_OFF_CTRL}, 32'h1, r);
        bus(1'b0, {24'h0, LPSC_OFF_STATUS}, 32'h0, r);
        check("restart", 32'({r[10:8], r[1:0]}), 32'h1C);
        w = $random(seed);
        w[2:0] = 3'h3;
        frame(w, 24);
        w[2:0] = 3'h7;
        frame(w, 24);
        bus(1'b0, {24'h0, LPSC_OFF_STATUS}, 32'h0, r);
        check("misorder", 32'({r[10:8], r[1:0]}), 32'h1A);
        bus(1'b1, 32'h0, 32'hFFFFFF, r);
        check_reg(0);
        give_verdict();
    end
endmodule
